// file: common/cas_pkg.sv
package cas_pkg;

	// Register sub-addresses
	localparam logic [7:0] ADDR_COLD_THRESHOLD = 8'h0B;
	localparam logic [7:0] ADDR_HOT_THRESHOLD = 8'h0C;
	localparam logic [7:0] ADDR_THRESHOLD_ALERT_EN = 8'h0D;
	localparam logic [7:0] ADDR_STAGE_ALERT_EN = 8'h0E;
	localparam logic [7:0] ADDR_LOOP_ALERT_EN = 8'h0F;
	localparam logic [7:0] ADDR_THRESHOLD_ALERT = 8'h36;
	localparam logic [7:0] ADDR_STAGE_ALERT = 8'h37;
	localparam logic [7:0] ADDR_LOOP_ALERT = 8'h38;
	localparam logic [7:0] ADDR_LIVE_CONDITION = 8'h39;

	// Field widths
	localparam int DATA_W = 16;
	localparam int THRESH_ALERT_W = 2;
	localparam int STAGE_ALERT_W = 11;
	localparam int LOOP_ALERT_W = 6;
	localparam int LOOP_SRC_W = 4;

	// Threshold alert bit positions
	localparam int BIT_THERMISTOR_HOT = 0;
	localparam int BIT_THERMISTOR_COLD = 1;

	// Stage-entry alert bit positions
	localparam int BIT_STAGE_BALANCE = 10;
	localparam int BIT_STAGE_TOPPING = 9;
	localparam int BIT_STAGE_SUSPENDED = 8;
	localparam int BIT_STAGE_PRECHARGE = 7;
	localparam int BIT_STAGE_BULK = 6;
	localparam int BIT_STAGE_THERM_PAUSE = 5;
	localparam int BIT_STAGE_TIMER_DONE = 4;
	localparam int BIT_STAGE_LOW_CURRENT_DONE = 3;
	localparam int BIT_STAGE_OVERTIME = 2;
	localparam int BIT_STAGE_ABSENT_PACK = 1;
	localparam int BIT_STAGE_SHORTED_PACK = 0;

	// Loop-entry alert bit positions
	localparam int BIT_LOOP_INPUT_UV = 3;
	localparam int BIT_LOOP_INPUT_LIMIT = 2;
	localparam int BIT_LOOP_CONST_CURRENT = 1;
	localparam int BIT_LOOP_CONST_VOLTAGE = 0;

	// Live condition bit positions
	localparam int BIT_LIVE_CHARGING = 13;
	localparam int BIT_LIVE_MPPT = 11;
	localparam int BIT_LIVE_BALANCE_QUEUED = 10;
	localparam int BIT_LIVE_GATE_SUPPLY_GOOD = 9;
	localparam int BIT_LIVE_CELL_COUNT_ERROR = 8;
	localparam int BIT_LIVE_CHARGE_PERMITTED = 6;
	localparam int BIT_LIVE_MISSING_RT = 5;
	localparam int BIT_LIVE_THERMAL_SHUTDOWN = 4;

	// Reset values
	localparam logic [15:0] RST_COLD_THRESHOLD = 16'h0000;
	localparam logic [15:0] RST_HOT_THRESHOLD = 16'h0000;
	localparam logic [1:0] RST_THRESHOLD_ALERT_EN = 2'h0;
	localparam logic [10:0] RST_STAGE_ALERT_EN = 11'h000;
	localparam logic [5:0] RST_LOOP_ALERT_EN = 6'h00;

	// Series cell count pins: a set bit marks a legal pin code
	localparam int CELL_PIN_W = 2;
	localparam logic [3:0] CELL_CODE_VALID = 4'h7;

	// Pin synchroniser depth fixed at three stages
	localparam int SYNC_STAGES = 3;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} cas_reg_req_t;

	typedef struct packed {
		logic mppt;
		logic balance_request;
		logic [CELL_PIN_W-1:0] series_count;
		logic gate_supply_good;
		logic missing_timing_resistor;
		logic die_over_temp;
	} cas_pins_t;

endpackage

// file: rtl/cas_pin_sync.sv
`timescale 1ns/1ns
module cas_pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Asynchronous pins in
	input wire logic [W-1:0] pin_async,
	// Settled value out
	output logic [W-1:0] pin_settled
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	wire [W-1:0] agree = ~(stage2 ^ stage3);
	wire [W-1:0] next_settled = (stage3 & agree) | (pin_settled & ~agree);

	generate
		if (W < 1) begin : g_bad
			$error("cas_pin_sync needs W of at least 1");
		end
	endgenerate

	// A bit moves only once the second and third stages agree
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			pin_settled <= '0;
		end else begin
			stage1 <= pin_async;
			stage2 <= stage1;
			stage3 <= stage2;
			pin_settled <= next_settled;
		end
	end

endmodule

// file: rtl/cas_alert_regs.sv
`timescale 1ns/1ns
module cas_alert_regs #(
	parameter int CELL_PIN_W = cas_pkg::CELL_PIN_W,
	parameter logic [15:0] COLD_THRESHOLD_RESET = cas_pkg::RST_COLD_THRESHOLD,
	parameter logic [15:0] HOT_THRESHOLD_RESET = cas_pkg::RST_HOT_THRESHOLD
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register access port
	input wire cas_pkg::cas_reg_req_t reg_req,
	output logic [15:0] rd_data,
	output logic rd_valid,
	// Charger sequencer and loop sources, same clock
	input wire logic [10:0] stage_active,
	input wire logic [3:0] loop_active,
	input wire logic charger_active,
	input wire logic charge_permitted,
	// Measurement result, same clock
	input wire logic [15:0] thermistor_ratio,
	// Pins and analog comparators, asynchronous
	input wire cas_pkg::cas_pins_t pins
);

	localparam int PIN_W = CELL_PIN_W + 5;

	generate
		if (CELL_PIN_W != cas_pkg::CELL_PIN_W) begin : g_bad_series_count_pins
			$error("cas_alert_regs: CELL_PIN_W must match the pin code table");
		end
		if ($bits(cas_pkg::cas_pins_t) != PIN_W) begin : g_bad_pins
			$error("cas_alert_regs: pin bundle width does not match the synchroniser");
		end
		if ((1 << CELL_PIN_W) > $bits(cas_pkg::CELL_CODE_VALID)) begin : g_bad_code
			$error("cas_alert_regs: pin code table too short for CELL_PIN_W");
		end
		if (cas_pkg::BIT_LIVE_CHARGING >= cas_pkg::DATA_W) begin : g_bad_live
			$error("cas_alert_regs: live bit positions exceed the bus word");
		end
		if (cas_pkg::LOOP_SRC_W > cas_pkg::LOOP_ALERT_W) begin : g_bad_loop
			$error("cas_alert_regs: more loop sources than loop alert bits");
		end
		if (cas_pkg::BIT_STAGE_BALANCE >= cas_pkg::STAGE_ALERT_W) begin : g_bad_stage
			$error("cas_alert_regs: stage bit positions exceed the stage alert field");
		end
	endgenerate

	// Sticky update: keep unless written zero or disabled; an event beats a zero write but not a disable
	function automatic logic [15:0] sticky_next(
		input logic [15:0] cur,
		input logic [15:0] evt,
		input logic [15:0] en,
		input logic hit,
		input logic [15:0] wdata
	);
		logic [15:0] keep;
		keep = hit ? wdata : 16'hFFFF;
		sticky_next = ((cur & keep) | evt) & en;
	endfunction

	// Write strobe aimed at one sub-address
	function automatic logic wr_hit(
		input cas_pkg::cas_reg_req_t req,
		input logic [7:0] target
	);
		wr_hit = req.wr && (req.addr == target);
	endfunction

	// Synchronised pins
	logic [PIN_W-1:0] pin_settled;
	cas_pin_sync #(
		.W(PIN_W)
	) u_pin_sync (
		.clk(clk),
		.rst_b(rst_b),
		.pin_async(pins),
		.pin_settled(pin_settled)
	);

	cas_pkg::cas_pins_t pin_s;
	assign pin_s = pin_settled;

	// Settled pin fields; each lags its pin by the synchroniser
	wire pin_mppt = pin_s.mppt;
	wire pin_balance = pin_s.balance_request;
	wire [CELL_PIN_W-1:0] pin_series_count = pin_s.series_count;
	wire pin_gate_supply_good = pin_s.gate_supply_good;
	wire pin_missing_rt = pin_s.missing_timing_resistor;
	wire pin_over_temp = pin_s.die_over_temp;

	// Stored registers
	logic [15:0] cold_threshold;
	logic [15:0] hot_threshold;
	logic [1:0] threshold_alert_en;
	logic [10:0] stage_alert_en;
	logic [5:0] loop_alert_en;
	logic [1:0] threshold_alert_flags;
	logic [10:0] stage_entry_alert_flags;
	logic [5:0] loop_entry_alert_flags;
	logic [15:0] live_condition_flags;
	logic [10:0] stage_prev;
	logic [3:0] loop_prev;
	logic balance_pin_prev;
	logic balance_queued;

	// Address decode; a read sharing a cycle with a write sees the old value
	wire [7:0] addr = reg_req.addr;
	wire [15:0] wdata = reg_req.wdata;
	wire wr_cold = wr_hit(reg_req, cas_pkg::ADDR_COLD_THRESHOLD);
	wire wr_hot = wr_hit(reg_req, cas_pkg::ADDR_HOT_THRESHOLD);
	wire wr_thr_en = wr_hit(reg_req, cas_pkg::ADDR_THRESHOLD_ALERT_EN);
	wire wr_stage_en = wr_hit(reg_req, cas_pkg::ADDR_STAGE_ALERT_EN);
	wire wr_loop_en = wr_hit(reg_req, cas_pkg::ADDR_LOOP_ALERT_EN);
	wire wr_thr_alert = wr_hit(reg_req, cas_pkg::ADDR_THRESHOLD_ALERT);
	wire wr_stage_alert = wr_hit(reg_req, cas_pkg::ADDR_STAGE_ALERT);
	wire wr_loop_alert = wr_hit(reg_req, cas_pkg::ADDR_LOOP_ALERT);

	// Threshold comparisons; a high ratio means a cold pack
	wire ratio_cold = thermistor_ratio > cold_threshold;
	wire ratio_hot = thermistor_ratio < hot_threshold;
	wire [15:0] thr_evt = {14'h0000, ratio_cold, ratio_hot};

	// Stage entry is the rising edge of each stage line
	wire [10:0] stage_entry = stage_active & ~stage_prev;
	wire [15:0] stage_evt = {5'h00, stage_entry};

	// Loop sources: gated to charging, lowest bit kept if several claim control
	wire loop_gate = charger_active;
	wire [3:0] loop_lowest = loop_active & (~loop_active + 4'h1);
	wire [3:0] loop_src = loop_gate ? loop_lowest : 4'h0;
	wire [3:0] loop_entry = loop_src & ~loop_prev;
	wire [15:0] loop_evt = {12'h000, loop_entry};

	// Stored fields widened to the bus word, shared by the update and the read mux
	wire [15:0] thr_en_word = {14'h0000, threshold_alert_en};
	wire [15:0] stage_en_word = {5'h00, stage_alert_en};
	wire [15:0] loop_en_word = {10'h000, loop_alert_en};
	wire [15:0] thr_flag_word = {14'h0000, threshold_alert_flags};
	wire [15:0] stage_flag_word = {5'h00, stage_entry_alert_flags};
	wire [15:0] loop_flag_word = {10'h000, loop_entry_alert_flags};

	// Sticky next values
	wire [15:0] thr_next = sticky_next(thr_flag_word, thr_evt, thr_en_word, wr_thr_alert,
		wdata);
	wire [15:0] stage_next = sticky_next(stage_flag_word, stage_evt, stage_en_word, wr_stage_alert,
		wdata);
	wire [15:0] loop_next = sticky_next(loop_flag_word, loop_evt, loop_en_word, wr_loop_alert,
		wdata);

	// Balance request queue: pin rising edge sets, entering balance stage clears
	wire balance_rise = pin_balance & ~balance_pin_prev;
	wire balance_taken = stage_entry[cas_pkg::BIT_STAGE_BALANCE];
	wire next_balance_queued = balance_rise | (balance_queued & ~balance_taken);

	// Cell pin code checked against the table of legal codes
	wire cell_code_bad = ~cas_pkg::CELL_CODE_VALID[pin_series_count];

	// Live condition word, rebuilt every cycle from its sources
	logic [15:0] next_live;
	always_comb begin
		next_live = 16'h0000;
		next_live[cas_pkg::BIT_LIVE_CHARGING] = charger_active;
		next_live[cas_pkg::BIT_LIVE_CHARGE_PERMITTED] = charge_permitted;
		next_live[cas_pkg::BIT_LIVE_MPPT] = pin_mppt;
		next_live[cas_pkg::BIT_LIVE_BALANCE_QUEUED] = balance_queued;
		next_live[cas_pkg::BIT_LIVE_GATE_SUPPLY_GOOD] = pin_gate_supply_good;
		next_live[cas_pkg::BIT_LIVE_CELL_COUNT_ERROR] = cell_code_bad;
		next_live[cas_pkg::BIT_LIVE_MISSING_RT] = pin_missing_rt;
		next_live[cas_pkg::BIT_LIVE_THERMAL_SHUTDOWN] = pin_over_temp;
	end

	// Read mux; unmapped sub-addresses read as zero
	logic [15:0] next_rd_data;
	always_comb begin
		case (addr)
			cas_pkg::ADDR_COLD_THRESHOLD: next_rd_data = cold_threshold;
			cas_pkg::ADDR_HOT_THRESHOLD: next_rd_data = hot_threshold;
			cas_pkg::ADDR_THRESHOLD_ALERT_EN: next_rd_data = thr_en_word;
			cas_pkg::ADDR_STAGE_ALERT_EN: next_rd_data = stage_en_word;
			cas_pkg::ADDR_LOOP_ALERT_EN: next_rd_data = loop_en_word;
			cas_pkg::ADDR_THRESHOLD_ALERT: next_rd_data = thr_flag_word;
			cas_pkg::ADDR_STAGE_ALERT: next_rd_data = stage_flag_word;
			cas_pkg::ADDR_LOOP_ALERT: next_rd_data = loop_flag_word;
			cas_pkg::ADDR_LIVE_CONDITION: next_rd_data = live_condition_flags;
			default: next_rd_data = 16'h0000;
		endcase
	end

	// Cold threshold
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cold_threshold <= COLD_THRESHOLD_RESET;
		end else if (wr_cold) begin
			cold_threshold <= wdata;
		end
	end

	// Hot threshold
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hot_threshold <= HOT_THRESHOLD_RESET;
		end else if (wr_hot) begin
			hot_threshold <= wdata;
		end
	end

	// Threshold alert enables; only the two thermistor bits are stored
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			threshold_alert_en <= cas_pkg::RST_THRESHOLD_ALERT_EN;
		end else if (wr_thr_en) begin
			threshold_alert_en <= wdata[1:0];
		end
	end

	// Stage alert enables
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage_alert_en <= cas_pkg::RST_STAGE_ALERT_EN;
		end else if (wr_stage_en) begin
			stage_alert_en <= wdata[10:0];
		end
	end

	// Loop alert enables; bits 5:4 are kept though no source feeds them
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loop_alert_en <= cas_pkg::RST_LOOP_ALERT_EN;
		end else if (wr_loop_en) begin
			loop_alert_en <= wdata[5:0];
		end
	end

	// Threshold alert flags
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			threshold_alert_flags <= 2'h0;
		end else begin
			threshold_alert_flags <= thr_next[1:0];
		end
	end

	// Stage-entry alert flags
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage_entry_alert_flags <= 11'h000;
		end else begin
			stage_entry_alert_flags <= stage_next[10:0];
		end
	end

	// Loop-entry alert flags
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loop_entry_alert_flags <= 6'h00;
		end else begin
			loop_entry_alert_flags <= loop_next[5:0];
		end
	end

	// Edge history starts at zero, so a stage already active after reset counts as entered
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage_prev <= 11'h000;
		end else begin
			stage_prev <= stage_active;
		end
	end

	// Loop history follows the gated source, so regaining charge control is a new entry
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loop_prev <= 4'h0;
		end else begin
			loop_prev <= loop_src;
		end
	end

	// Pin history idles low like the pin, so reset makes no false edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			balance_pin_prev <= 1'b0;
		end else begin
			balance_pin_prev <= pin_balance;
		end
	end

	// Queued balance request
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			balance_queued <= 1'b0;
		end else begin
			balance_queued <= next_balance_queued;
		end
	end

	// Live condition word, one register stage behind its sources
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			live_condition_flags <= 16'h0000;
		end else begin
			live_condition_flags <= next_live;
		end
	end

	// Read answer flag, one cycle after the strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= reg_req.rd;
		end
	end

	// Read data holds until the next read, so a slow host may take it late
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data <= 16'h0000;
		end else if (reg_req.rd) begin
			rd_data <= next_rd_data;
		end
	end

endmodule

// file: testbench/cas_alert_regs_sva.sv
`timescale 1ns/1ns
module cas_alert_regs_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Watched ports
	input wire cas_pkg::cas_reg_req_t reg_req,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input wire logic charger_active,
	input wire logic charge_permitted,
	input wire cas_pkg::cas_pins_t pins
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [3:0] age;
	wire rd_live = reg_req.rd && reg_req.addr == 8'h39;
	wire [7:0] ra = reg_req.addr;
	// Synchroniser flops start at zero, so live bits lag pins just after reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			age <= 4'h0;
		else if (age != 4'hF)
			age <= age + 4'h1;
	end
	sequence s_pins_settled;
		$stable(pins) [*7];
	endsequence
	sequence s_live_read;
		rd_live && age > 4'h8;
	endsequence
	a_rd_valid_pulse: assert property (reg_req.rd |=> rd_valid) else $error("no rd_valid after read");
	a_rd_valid_cause: assert property (!reg_req.rd |=> !rd_valid) else $error("stray rd_valid");
	a_rd_data_hold: assert property (!reg_req.rd |=> $stable(rd_data)) else $error("rd_data moved");
	a_live_core_bits: assert property (
		(rd_live && age > 4'h2 && $stable(charger_active) && $stable(charge_permitted)) |=>
		rd_data[13] == $past(charger_active) && rd_data[6] == $past(charge_permitted))
		else $error("live charging bits wrong");
	a_live_pin_bits: assert property (
		(s_pins_settled ##0 s_live_read) |=> rd_data[11] == $past(pins.mppt) &&
		rd_data[9] == $past(pins.gate_supply_good) && rd_data[5] == $past(pins.missing_timing_resistor) &&
		rd_data[4] == $past(pins.die_over_temp) && rd_data[8] == ($past(pins.series_count) == 2'h3))
		else $error("live pin bits wrong");
	a_live_spare_zero: assert property (rd_live |=> rd_data[15:14] == 2'h0 && !rd_data[12] &&
		!rd_data[7] && rd_data[3:0] == 4'h0) else $error("live spare bits set");
	a_loop_spare_zero: assert property (reg_req.rd && ra == 8'h38 |=> rd_data[15:4] == 12'h000)
		else $error("loop spare bits set");
	a_stage_spare_zero: assert property (reg_req.rd && ra == 8'h37 |=> rd_data[15:11] == 5'h00)
		else $error("stage spare bits set");
	a_unmapped_zero: assert property (reg_req.rd && (ra > 8'h39 || ra < 8'h0B) |=> rd_data == 16'h0000)
		else $error("unmapped read not zero");
endmodule

bind cas_alert_regs cas_alert_regs_sva u_sva (.clk(clk), .rst_b(rst_b), .reg_req(reg_req), .rd_data(rd_data),
	.rd_valid(rd_valid), .charger_active(charger_active), .charge_permitted(charge_permitted), .pins(pins));

// file: testbench/cas_host_model.sv
`timescale 1ns/1ns
module cas_host_model (
	// Clock
	input wire logic clk,
	// Register port
	output cas_pkg::cas_reg_req_t reg_req,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid
);
	initial reg_req = '0;
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		#1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		#1 reg_req.wr = 1'b0;
	endtask
	// Answer is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
		@(posedge clk);
		#1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk);
		#1 reg_req.rd = 1'b0;
		ok = rd_valid === 1'b1;
		d = rd_data;
	endtask
endmodule

// file: testbench/cas_alert_regs_tb.sv
`timescale 1ns/1ns
module cas_alert_regs_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	cas_pkg::cas_reg_req_t reg_req;
	logic [15:0] rd_data;
	logic rd_valid;
	logic [10:0] stage_active = 11'h000;
	logic [3:0] loop_active = 4'h0;
	logic charger_active = 1'b0;
	logic charge_permitted = 1'b0;
	logic [15:0] thermistor_ratio = 16'h0000;
	cas_pkg::cas_pins_t pins = '0;
	int n_fail = 0;
	int compares = 0;
	logic [15:0] exp_v;
	always #2 clk = ~clk;
	cas_alert_regs DUT (.clk(clk), .rst_b(rst_b), .reg_req(reg_req), .rd_data(rd_data), .rd_valid(rd_valid),
		.stage_active(stage_active), .loop_active(loop_active), .charger_active(charger_active),
		.charge_permitted(charge_permitted), .thermistor_ratio(thermistor_ratio), .pins(pins));
	cas_host_model host (.clk(clk), .reg_req(reg_req), .rd_data(rd_data), .rd_valid(rd_valid));
	task automatic summarize;
		if (n_fail == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic ok;
		host.rd(a, d, ok);
		compares++;
		if (d !== e) begin
			$display("FAIL reg %h expected %h seen %h", a, e, d);
			n_fail++;
		end
		if (!ok) begin
			$display("FAIL rd_valid expected 1 seen 0");
			n_fail++;
			summarize();
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	initial begin
		tick(8);
		rst_b = 1'b1;
		stage_active = 11'h040;
		tick(2);
		stage_active = 11'h000;
		rc(8'h37, 16'h0000);
		host.wr(8'h0E, 16'h07FF);
		exp_v = 16'h0000;
		for (int b = 0; b < 11; b++) begin
			stage_active = 11'h001 << b;
			tick(2);
			stage_active = 11'h000;
			exp_v[b] = 1'b1;
			rc(8'h37, exp_v);
		end
		host.wr(8'h37, 16'hFFFE);
		rc(8'h37, 16'h07FE);
		// New entry lands on the same edge as the clearing write
		fork
			host.wr(8'h37, 16'h0000);
			begin
				@(posedge clk);
				#1 stage_active = 11'h008;
			end
		join
		rc(8'h37, 16'h0008);
		host.wr(8'h0E, 16'h0000);
		rc(8'h37, 16'h0000);
		stage_active = 11'h000;
		host.wr(8'h0F, 16'h003F);
		loop_active = 4'hF;
		tick(2);
		loop_active = 4'h0;
		rc(8'h38, 16'h0000);
		charger_active = 1'b1;
		for (int b = 0; b < 4; b++) begin
			loop_active = 4'h1 << b;
			tick(2);
			loop_active = 4'h0;
			tick(1);
		end
		rc(8'h38, 16'h000F);
		host.wr(8'h38, 16'h0000);
		rc(8'h38, 16'h0000);
		// Two loops claim control; the lowest wins but its enable is off
		host.wr(8'h0F, 16'h003E);
		loop_active = 4'h3;
		tick(2);
		rc(8'h38, 16'h0000);
		loop_active = 4'h2;
		tick(2);
		loop_active = 4'h0;
		rc(8'h38, 16'h0002);
		host.wr(8'h0B, 16'h1000);
		host.wr(8'h0C, 16'h0800);
		thermistor_ratio = 16'h1000;
		host.wr(8'h0D, 16'h0003);
		rc(8'h36, 16'h0000);
		thermistor_ratio = 16'h1001;
		rc(8'h36, 16'h0002);
		thermistor_ratio = 16'h0800;
		rc(8'h36, 16'h0002);
		host.wr(8'h36, 16'h0000);
		rc(8'h36, 16'h0000);
		thermistor_ratio = 16'h07FF;
		rc(8'h36, 16'h0001);
		charge_permitted = 1'b1;
		pins = '{mppt: 1'b1, balance_request: 1'b0, series_count: 2'h3, gate_supply_good: 1'b1,
			missing_timing_resistor: 1'b1, die_over_temp: 1'b1};
		tick(8);
		rc(8'h39, 16'h2B70);
		pins.balance_request = 1'b1;
		tick(8);
		rc(8'h39, 16'h2F70);
		pins = '0;
		charger_active = 1'b0;
		charge_permitted = 1'b0;
		tick(8);
		rc(8'h39, 16'h0400);
		stage_active = 11'h400;
		tick(2);
		rc(8'h39, 16'h0000);
		rc(8'h50, 16'h0000);
		host.wr(8'h39, 16'hFFFF);
		rc(8'h39, 16'h0000);
		summarize();
	end
endmodule
